// ===== src/dop_point.sv
// Digital output point: command mapping, pulsing, fallback, reports, CRC.
`timescale 1ns/100ps
`default_nettype none
`include "dop_consts.svh"

module dop_point
    import dop_pkg::*;
#(
    parameter int TICK_CYCLES = `DOP_TICK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  first_channel,
    input  wire logic [3:0]  channel_count,
    input  wire logic [7:0]  deactivate_code,
    input  wire logic [7:0]  activate_code,
    input  wire logic        contact_sense,
    input  wire logic [15:0] pulse_tenths,
    input  wire logic [7:0]  offline_fallback_value,
    input  wire logic        link_watchdog_enable,
    input  wire logic        link_watchdog_offline,
    input  wire dop_report_t report_priority,
    input  wire logic [7:0]  max_interval_sec,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_value,
    input  wire logic        cos_request,
    input  wire logic        cfg_write,
    input  wire logic [7:0]  tag_addr,
    input  wire logic [7:0]  tag_wdata,
    input  wire logic        tag_we,
    input  wire logic [7:0]  desc_addr,
    input  wire logic [7:0]  desc_wdata,
    input  wire logic        desc_we,
    output logic [31:0] chan_out,
    output logic [7:0]  value,
    output logic [7:0]  raw_channel_bits,
    output logic [7:0]  point_status_code,
    output logic [31:0] last_change_time,
    output logic [15:0] config_crc,
    output logic        cos_valid,
    output logic        cos_high,
    output logic [7:0]  cos_value,
    output logic        tag_ok,
    output logic        desc_ok
);

    // Divider counter is 24 bits wide and needs at least two states
    if (TICK_CYCLES < 2 || TICK_CYCLES > 24'hFF_FFFF) begin : g_tick_chk
        $error("dop_point: TICK_CYCLES out of range");
    end

    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);

    // ------------------------------------------------------------------
    // Storage for tag and description text
    // ------------------------------------------------------------------
    logic [7:0] tag_mem  [`DOP_TAG_LEN];
    logic [7:0] desc_mem [`DOP_DESC_LEN];
    logic       tag_wr_ok;
    logic       desc_wr_ok;

    // Only printable bytes inside the field are accepted
    assign tag_wr_ok = tag_we && tag_addr < 8'(`DOP_TAG_LEN)
        && tag_wdata >= `DOP_ASCII_LO && tag_wdata <= `DOP_ASCII_HI;
    assign desc_wr_ok = desc_we && desc_addr < 8'(`DOP_DESC_LEN)
        && desc_wdata >= `DOP_ASCII_LO && desc_wdata <= `DOP_ASCII_HI;

    // Text arrays hold no reset; they are loaded by configuration
    always_ff @(posedge clk) begin
        if (tag_wr_ok) begin
            tag_mem[tag_addr[3:0]] <= tag_wdata;
        end
        if (desc_wr_ok) begin
            desc_mem[desc_addr[4:0]] <= desc_wdata;
        end
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    dop_state_t st_reg;
    dop_state_t st_next;

    logic [63:0] cfg_word;
    logic [7:0]  new_value;
    logic        new_valid;
    logic        tick;
    logic        sec_tick;
    logic [15:0] crc_calc;
    logic [7:0]  group_mask;
    logic [7:0]  level_bits;
    logic [31:0] spread;
    logic [7:0]  first_idx;
    logic        rpt_on;
    logic        off_edge;

    // ------------------------------------------------------------------
    // Configuration checksum and command selection
    // ------------------------------------------------------------------
    // Static configuration packed for checksum and change detection
    assign cfg_word = {first_channel, 4'h0, channel_count, deactivate_code,
                       activate_code, 7'h00, contact_sense, pulse_tenths,
                       offline_fallback_value};

    // Bitwise CRC-16 over eight bytes, evaluated combinationally
    function automatic logic [15:0] crc16(input logic [63:0] d);
        logic [15:0] c;
        c = `DOP_CRC_INIT;
        for (int i = 0; i < 64; i++) begin
            c = c ^ {15'h0000, d[i]};
            c = c[0] ? ((c >> 1) ^ `DOP_CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

    assign crc_calc = crc16(cfg_word);
    assign rpt_on   = report_priority != DOP_RPT_NO;
    assign off_edge = link_watchdog_offline && !st_reg.offline_seen;

    // Command source choice; offline fallback overrides a command
    always_comb begin
        new_valid = 1'b0;
        new_value = st_reg.value;
        if (cmd_valid) begin
            new_valid = 1'b1;
            new_value = cmd_value;
        end
        if (off_edge && link_watchdog_enable) begin
            new_valid = 1'b1;
            new_value = offline_fallback_value;
        end
        // Offline with no watchdog configured changes nothing
    end

    // ------------------------------------------------------------------
    // Channel mapping
    // ------------------------------------------------------------------
    // Group mask and offset of the first channel; an out-of-range first
    // channel falls back to channel 1 rather than losing the group
    always_comb begin
        group_mask = 8'h00;
        for (int i = 0; i < `DOP_MAX_GROUP; i++) begin
            if (4'(i) < channel_count) begin
                group_mask[i] = 1'b1;
            end
        end
        first_idx  = (first_channel == 8'h00 || first_channel > 8'd32)
            ? 8'h00 : first_channel - 8'h01;
    end

    // ------------------------------------------------------------------
    // Next state and state register
    // ------------------------------------------------------------------
    // Next state
    always_comb begin
        st_next = st_reg;
        tick = st_reg.tick_div == TICK_LAST;
        sec_tick = tick && st_reg.sec_div == 4'(`DOP_TICKS_PER_SEC - 1);
        // Base divider and second divider
        st_next.tick_div = tick ? 24'h00_0000 : st_reg.tick_div + 24'h00_0001;
        if (tick) begin
            st_next.now_ticks = st_reg.now_ticks + 32'h0000_0001;
            st_next.sec_div = sec_tick ? 4'h0 : st_reg.sec_div + 4'h1;
        end
        st_next.offline_seen = link_watchdog_offline;

        // Pulse countdown in tenths of a second
        if (st_reg.pulsing && tick) begin
            if (st_reg.pulse_left <= 16'h0001) begin
                st_next.pulsing = 1'b0;
                st_next.active  = 1'b0;
                st_next.value   = deactivate_code;
                st_next.change_pend = rpt_on;
                st_next.last_change = st_reg.now_ticks;
            end else begin
                st_next.pulse_left = st_reg.pulse_left - 16'h0001;
            end
        end

        // Commands drive the output only on an exact code match; the offline
        // fallback is forced even when it is neither of the two codes
        if (new_valid && (new_value == activate_code
                || new_value == deactivate_code
                || (off_edge && link_watchdog_enable))) begin
            st_next.active = new_value == activate_code;
            if (new_value != st_reg.value) begin
                st_next.change_pend = rpt_on;
                st_next.last_change = st_reg.now_ticks;
            end
            st_next.value = new_value;
            st_next.pulsing = new_value == activate_code
                && pulse_tenths != 16'h0000;
            st_next.pulse_left = pulse_tenths;
        end
        // Levels follow the resolved state, inverted for closed contacts
        level_bits = (st_next.active ^ contact_sense) ? group_mask
            : 8'h00;
        spread = 32'({24'h00_0000, level_bits} << first_idx[4:0]);
        st_next.chan_out = spread;
        st_next.raw = level_bits;

        // Interval resend counted in seconds, only when reporting
        if (!rpt_on || max_interval_sec == 8'h00) begin
            st_next.interval_sec = 8'h00;
            st_next.interval_due = 1'b0;
        end else if (sec_tick && !st_reg.interval_due) begin
            if (st_reg.interval_sec + 8'h01 >= max_interval_sec) begin
                st_next.interval_due = 1'b1;
            end else begin
                st_next.interval_sec = st_reg.interval_sec + 8'h01;
            end
        end
        if (!rpt_on) begin
            st_next.change_pend = 1'b0;
        end

        // Answer to a change-of-state request, one pulse
        st_next.cos_valid = 1'b0;
        if (cos_request && rpt_on
                && (st_reg.change_pend || st_reg.interval_due)) begin
            st_next.cos_valid = 1'b1;
            st_next.cos_high = report_priority == DOP_RPT_HIGH;
            st_next.cos_value = st_reg.value;
            st_next.interval_sec = 8'h00;
            st_next.interval_due = 1'b0;
            // A change arriving now is kept for the next request
            st_next.change_pend = st_next.value != st_reg.value;
        end

        // Checksum upkeep and status code
        st_next.crc = crc_calc;
        st_next.cfg_last = cfg_word;
        if (!st_reg.crc_ref_valid || cfg_write) begin
            st_next.crc_ref = crc_calc;
            st_next.crc_ref_valid = 1'b1;
        end
        if (cfg_word != st_reg.cfg_last && st_reg.crc_ref_valid) begin
            st_next.status = `DOP_STAT_CFG_CHG;
        end else if (cfg_write) begin
            st_next.status = `DOP_STAT_OK;
        end else if (st_reg.crc_ref_valid && st_reg.crc != st_reg.crc_ref
                && st_reg.status != `DOP_STAT_CFG_CHG) begin
            st_next.status = `DOP_STAT_CRC_ERR;
        end
        if (tag_wr_ok) begin
            st_next.tag_ok = 1'b1;
        end
        if (desc_wr_ok) begin
            st_next.desc_ok = 1'b1;
        end
    end

    // Single register bank for all state except the tag and description text arrays
    always_ff @(posedge clk) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.value <= `DOP_CODE_OFF;
            st_reg.crc <= `DOP_CRC_INIT;
            st_reg.crc_ref <= `DOP_CRC_INIT;
            st_reg.status <= `DOP_STAT_OK;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Outputs straight from the state register
    assign chan_out          = st_reg.chan_out;
    assign value             = st_reg.value;
    assign raw_channel_bits  = st_reg.raw;
    assign point_status_code = st_reg.status;
    assign last_change_time  = st_reg.last_change;
    assign config_crc        = st_reg.crc;
    assign cos_valid         = st_reg.cos_valid;
    assign cos_high          = st_reg.cos_high;
    assign cos_value         = st_reg.cos_value;
    assign tag_ok            = st_reg.tag_ok;
    assign desc_ok           = st_reg.desc_ok;

endmodule

`default_nettype wire

// ===== common/dop_consts.svh
// Constants for the digital output point: field widths, defaults, timing.
`ifndef DOP_CONSTS_SVH
`define DOP_CONSTS_SVH

`define DOP_CLK_HZ         25000000
`define DOP_TICK_MS        100
`define DOP_TICK_CYCLES    ((`DOP_CLK_HZ / 1000) * `DOP_TICK_MS)
`define DOP_TICKS_PER_SEC  10
`define DOP_NUM_CHANNELS   32
`define DOP_MAX_GROUP      8
`define DOP_FIRST_CH_DEF   8'h01
`define DOP_GROUP_DEF      4'h1
`define DOP_CODE_OFF       8'h00
`define DOP_CODE_ON        8'h01
`define DOP_STAT_OK        8'h00
`define DOP_STAT_CFG_CHG   8'h03
`define DOP_STAT_CRC_ERR   8'h04
`define DOP_CRC_POLY       16'hA001
`define DOP_CRC_INIT       16'hFFFF
`define DOP_TAG_LEN        15
`define DOP_DESC_LEN       30
`define DOP_ASCII_LO       8'h20
`define DOP_ASCII_HI       8'h7E

`endif

// ===== common/dop_pkg.sv
// Types shared by the digital output point.
`default_nettype none
package dop_pkg;
    typedef enum logic [1:0] {
        DOP_RPT_NO,
        DOP_RPT_LOW,
        DOP_RPT_HIGH
    } dop_report_t;

    typedef struct packed {
        logic [31:0] chan_out;
        logic [7:0]  value;
        logic        active;
        logic [15:0] pulse_left;
        logic        pulsing;
        logic [23:0] tick_div;
        logic [3:0]  sec_div;
        logic [7:0]  interval_sec;
        logic        interval_due;
        logic        change_pend;
        logic        offline_seen;
        logic [31:0] last_change;
        logic [31:0] now_ticks;
        logic [15:0] crc;
        logic [15:0] crc_ref;
        logic        crc_ref_valid;
        logic [63:0] cfg_last;
        logic [7:0]  status;
        logic        cos_valid;
        logic        cos_high;
        logic [7:0]  cos_value;
        logic [7:0]  raw;
        logic        tag_ok;
        logic        desc_ok;
    } dop_state_t;
endpackage

`default_nettype wire

// ===== verif/dop_point_asserts.sv
// Port assertions for the digital output point.
`timescale 1ns/100ps
`default_nettype none

module dop_point_asserts
    import dop_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  deactivate_code,
    input wire logic [7:0]  activate_code,
    input wire logic [15:0] pulse_tenths,
    input wire logic [7:0]  offline_fallback_value,
    input wire logic        link_watchdog_enable,
    input wire logic        link_watchdog_offline,
    input wire dop_report_t report_priority,
    input wire logic        cmd_valid,
    input wire logic [7:0]  cmd_value,
    input wire logic        cos_request,
    input wire logic        cfg_write,
    input wire logic [7:0]  tag_addr,
    input wire logic [7:0]  tag_wdata,
    input wire logic        tag_we,
    input wire logic [7:0]  desc_addr,
    input wire logic [7:0]  desc_wdata,
    input wire logic        desc_we,
    input wire logic [7:0]  value,
    input wire logic [7:0]  point_status_code,
    input wire logic [31:0] last_change_time,
    input wire logic        cos_valid,
    input wire logic        cos_high,
    input wire logic        tag_ok,
    input wire logic        desc_ok
);
    // Single domain, so one clocking and one disable serve all
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    act_cmd_a: assert property (cmd_valid && cmd_value == activate_code
        && !link_watchdog_enable |=> value == activate_code)
        else $error("activate command not applied");
    deact_cmd_a: assert property (cmd_valid && !link_watchdog_enable
        && cmd_value == deactivate_code |=> value == deactivate_code)
        else $error("deactivate command not applied");
    fallback_value_a: assert property (link_watchdog_enable
        && $rose(link_watchdog_offline) |=> value == offline_fallback_value)
        else $error("offline fallback not applied");
    value_hold_a: assert property (!link_watchdog_enable && !cmd_valid
        && pulse_tenths == 16'h0000 |=> $stable(value))
        else $error("value moved without a command");
    no_report_a: assert property (cos_request
        && report_priority == DOP_RPT_NO |=> !cos_valid)
        else $error("report sent with reporting off");
    report_cause_a: assert property (cos_valid |-> $past(cos_request)
        && $past(report_priority) != DOP_RPT_NO)
        else $error("report without a request");
    report_rank_a: assert property (cos_valid |->
        cos_high == ($past(report_priority) == DOP_RPT_HIGH))
        else $error("report priority flag wrong");
    status_clear_a: assert property (cfg_write |-> ##[1:3]
        point_status_code == 8'h00)
        else $error("status not cleared by commit");
    stamp_hold_a: assert property ($stable(value) |->
        $stable(last_change_time))
        else $error("timestamp moved without a change");
    tag_store_a: assert property ($rose(tag_ok) |-> $past(tag_we)
        && $past(tag_addr) < 8'd15 && $past(tag_wdata) inside {[8'h20:8'h7E]})
        else $error("bad tag byte accepted");
    desc_store_a: assert property ($rose(desc_ok) |-> $past(desc_we)
        && $past(desc_addr) < 8'd30 && $past(desc_wdata) inside {[8'h20:8'h7E]})
        else $error("bad description byte accepted");
endmodule

bind dop_point dop_point_asserts chk_u (.clk(clk), .reset(reset),
    .deactivate_code(deactivate_code), .activate_code(activate_code),
    .pulse_tenths(pulse_tenths), .offline_fallback_value(offline_fallback_value),
    .link_watchdog_enable(link_watchdog_enable),
    .link_watchdog_offline(link_watchdog_offline),
    .report_priority(report_priority), .cmd_valid(cmd_valid),
    .cmd_value(cmd_value), .cos_request(cos_request), .cfg_write(cfg_write),
    .tag_addr(tag_addr), .tag_wdata(tag_wdata), .tag_we(tag_we),
    .desc_addr(desc_addr), .desc_wdata(desc_wdata), .desc_we(desc_we),
    .value(value), .point_status_code(point_status_code),
    .last_change_time(last_change_time), .cos_valid(cos_valid),
    .cos_high(cos_high), .tag_ok(tag_ok), .desc_ok(desc_ok));

`default_nettype wire

// ===== verif/dop_chan_load.sv
// Model of the field loads: which contacts of the group are energised.
`timescale 1ns/100ps
`default_nettype none

module dop_chan_load (
    input  wire logic [31:0] chan_out,
    input  wire logic [7:0]  first_channel,
    input  wire logic [3:0]  channel_count,
    input  wire logic        contact_sense,
    output logic [7:0]  load_on
);
    int idx;
    // Walk the group; normally closed wiring flips the meaning of a level
    always_comb begin
        load_on = 8'h00;
        for (int i = 0; i < 8; i++) begin
            idx = int'(first_channel) - 1 + i;
            if (i < int'(channel_count) && idx >= 0 && idx < 32) begin
                load_on[i] = chan_out[idx] ^ contact_sense;
            end
        end
    end
endmodule

`default_nettype wire

// ===== verif/dop_point_tb.sv
// Self-checking bench for the digital output point.
`timescale 1ns/100ps
`default_nettype none

module dop_point_tb;
    import dop_pkg::*;
    logic clk = 0, reset = 1, contact_sense = 0, wd_en = 0, wd_off = 0;
    logic cmd_valid = 0, cos_request = 0, cfg_write = 0;
    logic tag_we = 0, desc_we = 0, cos_valid, cos_high, tag_ok, desc_ok;
    logic [7:0] first_channel = 8'h03, act = 8'h01, deact = 8'h00, fb = 8'h02;
    logic [7:0] cmd_value = 8'h00, max_int = 8'h00, cos_value, value, raw;
    logic [7:0] tag_addr = 0, tag_wdata = 0, desc_addr = 0, desc_wdata = 0;
    logic [7:0] status, load_on;
    logic [3:0] channel_count = 4'h2;
    logic [15:0] pulse_tenths = 16'h0000, crc, c0;
    logic [31:0] chan_out, stamp, t0;
    dop_report_t prio = DOP_RPT_NO;
    int n_mismatch = 0, checked = 0, cycles = 0;

    always #20 clk = ~clk;

    dop_point #(.TICK_CYCLES(10)) dut_u (.clk(clk), .reset(reset),
        .first_channel(first_channel), .channel_count(channel_count),
        .deactivate_code(deact), .activate_code(act),
        .contact_sense(contact_sense), .pulse_tenths(pulse_tenths),
        .offline_fallback_value(fb), .link_watchdog_enable(wd_en),
        .link_watchdog_offline(wd_off), .report_priority(prio),
        .max_interval_sec(max_int), .cmd_valid(cmd_valid),
        .cmd_value(cmd_value), .cos_request(cos_request),
        .cfg_write(cfg_write), .tag_addr(tag_addr), .tag_wdata(tag_wdata),
        .tag_we(tag_we), .desc_addr(desc_addr), .desc_wdata(desc_wdata),
        .desc_we(desc_we), .chan_out(chan_out), .value(value),
        .raw_channel_bits(raw), .point_status_code(status),
        .last_change_time(stamp), .config_crc(crc), .cos_valid(cos_valid),
        .cos_high(cos_high), .cos_value(cos_value), .tag_ok(tag_ok),
        .desc_ok(desc_ok));

    dop_chan_load load_u (.chan_out(chan_out), .first_channel(first_channel),
        .channel_count(channel_count), .contact_sense(contact_sense),
        .load_on(load_on));

    // ----------------------------------------
    // Access tasks and reporting
    // ----------------------------------------
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Commands and requests are one-cycle pulses; answer lands at the edge
    task automatic cmd(input logic [7:0] v);
        @(posedge clk) begin cmd_valid <= 1; cmd_value <= v; end
        @(posedge clk) cmd_valid <= 0;
        #1;
    endtask

    task automatic poll(output logic [7:0] got);
        @(posedge clk) cos_request <= 1;
        @(posedge clk) cos_request <= 0;
        #1 got = {cos_high, 6'h00, cos_valid};
    endtask

    task automatic commit;
        @(posedge clk) cfg_write <= 1;
        @(posedge clk) cfg_write <= 0;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task automatic text(input bit d, input logic [7:0] a, input logic [7:0] w);
        @(posedge clk) begin
            if (d) begin desc_addr <= a; desc_wdata <= w; desc_we <= 1; end
            else begin tag_addr <= a; tag_wdata <= w; tag_we <= 1; end
        end
        @(posedge clk) begin tag_we <= 0; desc_we <= 0; end
        #1;
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    // Hang guard, well above the roughly 420 cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            conclude;
        end
    end

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    logic [7:0] r;
    logic [31:0] map [4] = '{32'h8000_0000, 0, 32'h0000_00FF, 32'hFF00_0000};
    logic [7:0] fcs [4] = '{8'd32, 8'd1, 8'd1, 8'd25};
    logic [3:0] ccs [4] = '{4'd8, 4'd0, 4'd8, 4'd8};
    initial begin
        repeat (12) @(posedge clk);
        reset <= 0;
        idle(1);
        check("status", status, 8'h00);
        cmd(8'h01);
        check("value", value, 8'h01);
        check("chan_out", chan_out, 32'h0000_000C);
        check("raw", raw, 8'h03);
        check("load", load_on, 8'h03);
        t0 = stamp;
        idle(12);
        cmd(8'h55);
        check("ignored", value, 8'h01);
        check("stamp", stamp, t0);
        cmd(8'h00);
        check("chan_off", chan_out, 32'h0);
        check("stamp_new", stamp > t0, 1'b1);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk) begin first_channel <= fcs[i];
                channel_count <= ccs[i]; end
            cmd(8'h01);
            check("edge_map", chan_out, map[i]);
            cmd(8'h00);
        end
        @(posedge clk) begin first_channel <= 8'h03; channel_count <= 4'h2;
            contact_sense <= 1; end
        cmd(8'h01);
        check("nc_on", chan_out, 32'h0);
        check("nc_load", load_on, 8'h03);
        cmd(8'h00);
        check("nc_off", chan_out, 32'h0000_000C);
        @(posedge clk) begin contact_sense <= 0; pulse_tenths <= 16'h0003; end
        $display("mapping test done");
        cmd(8'h01);
        idle(15);
        check("pulse_on", value, 8'h01);
        idle(20);
        check("pulse_end", value, 8'h00);
        @(posedge clk) pulse_tenths <= 16'h0000;
        cmd(8'h01);
        @(posedge clk) wd_off <= 1;
        idle(3);
        check("no_watchdog", value, 8'h01);
        @(posedge clk) begin wd_off <= 0; wd_en <= 1; end
        @(posedge clk) wd_off <= 1;
        idle(2);
        check("fallback", value, fb);
        @(posedge clk) begin wd_off <= 0; wd_en <= 0; end
        $display("pulse and offline test done");
        cmd(8'h01);
        poll(r);
        check("report_off", r[0], 1'b0);
        for (int p = 0; p < 2; p++) begin
            @(posedge clk) prio <= p ? DOP_RPT_LOW : DOP_RPT_HIGH;
            cmd(p ? 8'h01 : 8'h00);
            poll(r);
            check("report", r, {p == 0, 7'h01});
            check("report_val", cos_value, p ? act : deact);
            poll(r);
            check("no_resend", r[0], 1'b0);
        end
        @(posedge clk) max_int <= 8'h01;
        idle(130);
        poll(r);
        check("interval", r[0], 1'b1);
        @(posedge clk) prio <= DOP_RPT_NO;
        idle(130);
        poll(r);
        check("interval_off", r[0], 1'b0);
        @(posedge clk) max_int <= 8'h00;
        $display("report test done");
        commit;
        check("committed", status, 8'h00);
        c0 = {16'h0000, crc};
        @(posedge clk) channel_count <= 4'h3;
        idle(3);
        check("cfg_change", status, 8'h03);
        check("crc_moved", crc != c0[15:0], 1'b1);
        @(posedge clk) channel_count <= 4'h2;
        idle(3);
        check("crc_back", crc, c0);
        commit;
        check("recommit", status, 8'h00);
        text(0, 8'h00, 8'h19);
        text(0, 8'h0F, 8'h41);
        check("tag_bad", tag_ok, 1'b0);
        text(0, 8'h0E, 8'h7E);
        check("tag_good", tag_ok, 1'b1);
        text(1, 8'h1E, 8'h41);
        check("desc_bad", desc_ok, 1'b0);
        text(1, 8'h1D, 8'h20);
        check("desc_good", desc_ok, 1'b1);
        $display("status and text test done");
        conclude;
    end
endmodule

`default_nettype wire
